// *** sim/bus_memory_model.sv ***
// memory and peripheral model on the far side of the bus
`timescale 1ns/1ns
module bus_memory_model (
  input wire logic clk_sys,
  input wire logic [15:0] addr_bus,
  input wire logic [7:0] data_out,
  input wire logic valid_memory_access,
  input wire logic read_not_write,
  output logic [7:0] data_in
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_reg = 8'h00;
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = i[7:0] ^ i[15:8];
  end
  // writes only while the access line is high; last_reg follows data_in every cycle
  always @(posedge clk_sys)
  begin
    if (valid_memory_access && !read_not_write)
      mem[addr_bus] <= data_out;
    last_reg <= data_in;
  end
  // idle cycles carry no usable data
  assign data_in = (valid_memory_access && read_not_write) ? mem[addr_bus] : ~last_reg;
endmodule

// *** sim/cpu_bus_cycle_sequencer_asserts.sv ***
// bus cycle checker for the sequencer
`timescale 1ns/1ns
module cpu_bus_cycle_sequencer_asserts
  import seq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  input wire seq_pkg::op_class_type op_class,
  input wire logic test_only,
  input wire logic acc_b_sel,
  input wire logic [15:0] pc,
  input wire logic [7:0] acc_a,
  input wire logic [7:0] data_in,
  input wire logic [15:0] addr_bus,
  input wire logic [7:0] data_out,
  input wire logic valid_memory_access,
  input wire logic read_not_write,
  input wire logic busy,
  input wire logic done,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data
);
  logic taken;
  assign taken = start && (!busy || done);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_first_fetch:
    assert property (taken |=> addr_bus == $past(pc) && valid_memory_access && read_not_write)
    else $error("opcode fetch wrong");
  a_acc_store:
    assert property (taken && op_class == CLS_DIR_ACC_STORE && !test_only && !acc_b_sel
      |=> ##2 !valid_memory_access ##1 valid_memory_access && !read_not_write
      && data_out == $past(acc_a, 4) && done)
    else $error("accumulator store wrong");
  a_test_write:
    assert property (taken && op_class == CLS_DIR_ACC_STORE && test_only
      |=> ##3 !valid_memory_access && done)
    else $error("test write reached memory");
  a_soft_vector:
    assert property (taken && op_class == CLS_SOFT_INT |=> ##10 addr_bus == VEC_SOFT_INT_HI
      && valid_memory_access ##1 addr_bus == VEC_SOFT_INT_LO && done)
    else $error("vector fetch wrong");
  a_branch_idle:
    assert property (taken && op_class == CLS_BRANCH |=> ##2 !valid_memory_access
      && addr_bus == $past(pc, 3) + 16'h0002 ##1 !valid_memory_access && done)
    else $error("branch cycles wrong");
  a_bsr_last:
    assert property (taken && op_class == CLS_BRANCH_SUB |=> ##7 !valid_memory_access
      && (addr_bus & 16'hff00) == ($past(pc, 8) & 16'hff00) && done)
    else $error("subroutine last address wrong");
  a_rti_discard:
    assert property (taken && op_class == CLS_RETURN_INT |=> ##2 !rd_valid
      && !valid_memory_access ##1 valid_memory_access && read_not_write)
    else $error("return cycle two reported");
  a_rd_report:
    assert property (rd_valid |-> $past(valid_memory_access) && $past(read_not_write)
      && rd_data == $past(data_in))
    else $error("read report wrong");
endmodule
bind cpu_bus_cycle_sequencer cpu_bus_cycle_sequencer_asserts chk (.clk_sys, .rst_n,
  .start, .op_class, .test_only, .acc_b_sel, .pc, .acc_a, .data_in, .addr_bus,
  .data_out, .valid_memory_access, .read_not_write, .busy, .done, .rd_valid, .rd_data);

// *** sim/tb_cpu_bus_cycle_sequencer.sv ***
// self-checking bench for the bus cycle sequencer
`timescale 1ns/1ns
module tb_cpu_bus_cycle_sequencer;
  import seq_pkg::*;
  logic clk_sys = 0, rst_n = 0, start = 0, test_only = 0, acc_b_sel = 0, word_ix_sel = 1;
  op_class_type op_class = CLS_IMM8;
  logic [15:0] pc = 16'h12a0, sp = 16'h0f80, ix = 16'h20f0;
  logic [7:0] acc_a = 8'ha1, acc_b = 8'hb2, ccr = 8'hc3, data_in, data_out, rd_data, off;
  logic [15:0] addr_bus, p1, d, tgt;
  logic valid_memory_access, read_not_write, busy, done, rd_valid;
  logic [3:0] rd_cycle;
  logic [7:0] stk [0:6];
  int n_mismatch = 0, checks = 0, cycles = 0;
  cpu_bus_cycle_sequencer dut (.clk_sys, .rst_n, .start, .op_class, .test_only,
    .acc_b_sel, .word_ix_sel, .pc, .sp, .ix, .acc_a, .acc_b, .ccr, .data_in, .addr_bus,
    .data_out, .valid_memory_access, .read_not_write, .busy, .done, .rd_valid, .rd_data,
    .rd_cycle);
  bus_memory_model mem_model (.clk_sys, .addr_bus, .data_out, .valid_memory_access,
    .read_not_write, .data_in);
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [15:0] a, input logic v, input logic r);
    cmp(addr_bus, a);
    cmp({14'h0000, valid_memory_access, read_not_write}, {14'h0000, v, r});
    // cycles with read_not_write high keep the data lines at zero
    if (r)
      cmp({8'h00, data_out}, 16'h0000);
    @(negedge clk_sys);
  endtask
  // read report of the cycle just ended: valid, cycle number, byte
  task automatic rd(input logic [7:0] v, input logic [3:0] c);
    cmp({3'b000, rd_valid, rd_cycle, rd_data}, {4'h1, c, v});
  endtask
  // launches one sequence and checks the two fetch cycles
  task automatic go(input op_class_type c, input logic t);
    @(negedge clk_sys);
    op_class = c;
    test_only = t;
    start = 1;
    @(negedge clk_sys);
    start = 0;
    bus(pc, 1, 1);
    bus(p1, 1, 1);
  endtask
  task automatic stack7;
    for (int k = 0; k < 7; k++)
    begin
      cmp({8'h00, data_out}, {8'h00, stk[k]});
      bus(sp - 16'(k), 1, 0);
    end
    for (int k = 0; k < 7; k++)
      cmp({8'h00, mem_model.mem[sp - 16'(k)]}, {8'h00, stk[k]});
  endtask
  task automatic t_read;
    go(CLS_IMM16, 0);
    bus(pc + 16'h0002, 1, 1);
    go(CLS_DIR16, 0);
    bus(d, 1, 1);
    bus(d + 16'h0001, 1, 1);
    $display("test read done");
  endtask
  task automatic t_store;
    go(CLS_DIR_ACC_STORE, 1);
    bus(d, 0, 1);
    bus(d, 0, 0);
    cmp({8'h00, mem_model.mem[d]}, {8'h00, off});
    go(CLS_DIR_ACC_STORE, 0);
    bus(d, 0, 1);
    bus(d, 1, 0);
    cmp({8'h00, mem_model.mem[d]}, {8'h00, acc_a});
    go(CLS_DIR_WORD_STORE, 0);
    bus(d, 0, 1);
    bus(d, 1, 0);
    bus(d + 16'h0001, 1, 0);
    cmp({mem_model.mem[d], mem_model.mem[d + 16'h0001]}, ix);
    $display("test store done");
  endtask
  task automatic t_index;
    go(CLS_IDX_JUMP, 0);
    bus(ix, 0, 1);
    bus({ix[15:8], ix[7:0] + off}, 0, 1);
    go(CLS_IDX16, 0);
    bus(ix, 0, 1);
    bus({ix[15:8], ix[7:0] + off}, 0, 1);
    bus(ix + d, 1, 1);
    bus(ix + d + 16'h0001, 1, 1);
    $display("test index done");
  endtask
  task automatic t_stack;
    go(CLS_WAIT, 0);
    stack7();
    go(CLS_SOFT_INT, 0);
    stack7();
    bus(sp - 16'h0007, 0, 1);
    bus(16'hfffa, 1, 1);
    bus(16'hfffb, 1, 1);
    go(CLS_RETURN_INT, 0);
    cmp({15'h0000, rd_valid}, 16'h0000);
    bus(sp, 0, 1);
    for (int k = 1; k < 8; k++)
      bus(sp + 16'(k), 1, 1);
    rd(mem_model.mem[sp + 16'h0007], 4'ha);
    $display("test stack done");
  endtask
  task automatic t_branch;
    go(CLS_BRANCH, 0);
    bus(pc + 16'h0002, 0, 1);
    bus(tgt, 0, 1);
    go(CLS_BRANCH_SUB, 0);
    bus(pc + 16'h0002, 0, 1);
    bus(sp, 1, 0);
    bus(sp - 16'h0001, 1, 0);
    bus(sp - 16'h0002, 0, 1);
    bus(pc + 16'h0002, 0, 1);
    bus({pc[15:8], tgt[7:0]}, 0, 1);
    cmp({mem_model.mem[sp - 16'h0001], mem_model.mem[sp]}, pc + 16'h0002);
    $display("test branch done");
  endtask
  // a start held through a sequence is refused until its last cycle
  task automatic t_chain;
    @(negedge clk_sys);
    op_class = CLS_IMM8;
    test_only = 0;
    start = 1;
    @(negedge clk_sys);
    op_class = CLS_DIR8;
    cmp({14'h0000, busy, done}, 16'h0002);
    bus(pc, 1, 1);
    cmp({14'h0000, busy, done}, 16'h0003);
    bus(p1, 1, 1);
    start = 0;
    bus(pc, 1, 1);
    bus(p1, 1, 1);
    rd(off, 4'h2);
    cmp({14'h0000, busy, done}, 16'h0003);
    bus(d, 1, 1);
    rd(mem_model.mem[d], 4'h3);
    cmp({14'h0000, busy, done}, 16'h0000);
    acc_b_sel = 1;
    word_ix_sel = 0;
    go(CLS_DIR_ACC_STORE, 0);
    bus(d, 0, 1);
    cmp({8'h00, data_out}, {8'h00, acc_b});
    bus(d, 1, 0);
    cmp({8'h00, mem_model.mem[d]}, {8'h00, acc_b});
    go(CLS_DIR_WORD_STORE, 0);
    bus(d, 0, 1);
    bus(d, 1, 0);
    bus(d + 16'h0001, 1, 0);
    cmp({mem_model.mem[d], mem_model.mem[d + 16'h0001]}, sp);
    go(CLS_IDX8, 0);
    bus(ix, 0, 1);
    bus({ix[15:8], ix[7:0] + off}, 0, 1);
    bus(ix + d, 1, 1);
    rd(mem_model.mem[ix + d], 4'h5);
    $display("test chain done");
  endtask
  // reset in the middle of a stacking sequence, then a fresh start
  task automatic t_reset;
    go(CLS_WAIT, 0);
    rst_n = 0;
    @(negedge clk_sys);
    cmp(addr_bus, ADDR_RESET);
    cmp({13'h0000, valid_memory_access, read_not_write, busy}, 16'h0002);
    cmp({data_out, 6'h00, done, rd_valid}, {DATA_RESET, 8'h00});
    rst_n = 1;
    go(CLS_IMM8, 0);
    cmp({14'h0000, busy, done}, 16'h0000);
    $display("test reset done");
  endtask
  initial
  begin
    p1 = pc + 16'h0001;
    off = p1[7:0] ^ p1[15:8];
    d = {8'h00, off};
    tgt = pc + 16'h0002 + {{8{off[7]}}, off};
    stk = '{p1[7:0], p1[15:8], ix[7:0], ix[15:8], acc_a, acc_b, ccr};
    repeat (20) @(negedge clk_sys);
    rst_n = 1;
    t_read();
    t_store();
    t_index();
    t_stack();
    t_branch();
    t_chain();
    t_reset();
    conclude();
  end
endmodule

// *** verilog/bus_addr_calc.sv ***
// address arithmetic for the bus cycle sequencer
`timescale 1ns/1ns
module bus_addr_calc (
  input wire logic [15:0] pc,
  input wire logic [15:0] ix,
  input wire logic [7:0] offset,
  output logic [15:0] pc_plus1,
  output logic [15:0] pc_plus2,
  output logic [15:0] branch_target,
  output logic [15:0] idx_no_carry,
  output logic [15:0] idx_full
);
  always_comb
  begin
    pc_plus1 = pc + 16'h0001;
    pc_plus2 = pc + 16'h0002;
    branch_target = pc_plus2 + {{8{offset[7]}}, offset};
    // low byte sum only, the high byte is not yet corrected
    idx_no_carry = {ix[15:8], 8'(ix[7:0] + offset)};
    idx_full = ix + {8'h00, offset};
  end
endmodule

// *** verilog/cpu_bus_cycle_sequencer.sv ***
// cycle-by-cycle bus sequencer of the 8-bit processor core
`timescale 1ns/1ns
module cpu_bus_cycle_sequencer (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  input wire seq_pkg::op_class_type op_class,
  input wire logic test_only,
  input wire logic acc_b_sel,
  input wire logic word_ix_sel,
  input wire logic [15:0] pc,
  input wire logic [15:0] sp,
  input wire logic [15:0] ix,
  input wire logic [7:0] acc_a,
  input wire logic [7:0] acc_b,
  input wire logic [7:0] ccr,
  input wire logic [7:0] data_in,
  output logic [15:0] addr_bus,
  output logic [7:0] data_out,
  output logic valid_memory_access,
  output logic read_not_write,
  output logic busy,
  output logic done,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic [3:0] rd_cycle
);
  import seq_pkg::*;

  seq_state_type state_reg;
  op_class_type class_reg;
  logic [3:0] cycle_reg;
  logic [3:0] cycle_next;
  logic [7:0] offset_reg;
  logic [7:0] offset_now;
  logic test_reg;
  logic acc_b_reg;
  logic word_ix_reg;
  logic [15:0] pc_reg;
  logic [15:0] sp_reg;
  logic [15:0] ix_reg;
  logic [7:0] acc_a_reg;
  logic [7:0] acc_b_val_reg;
  logic [7:0] ccr_reg;
  logic last_cycle;
  logic accept;
  logic [15:0] pc_plus1;
  logic [15:0] pc_plus2;
  logic [15:0] branch_target;
  logic [15:0] idx_no_carry;
  logic [15:0] idx_full;
  logic [15:0] direct_addr;
  logic [15:0] ret_addr;
  logic [15:0] store_word;
  logic [15:0] nx_addr;
  logic [7:0] nx_data;
  logic nx_vma;
  logic nx_rnw;
  logic [3:0] stk_k;
  logic [15:0] stk_k16;
  op_class_type nx_class;

  function automatic logic [3:0] class_length(input op_class_type c);
    case (c)
      CLS_IMM8: class_length = LEN_IMM8;
      CLS_IMM16: class_length = LEN_IMM16;
      CLS_DIR8: class_length = LEN_DIR8;
      CLS_DIR16: class_length = LEN_DIR16;
      CLS_DIR_ACC_STORE: class_length = LEN_DIR_ACC_STORE;
      CLS_DIR_WORD_STORE: class_length = LEN_DIR_WORD_STORE;
      CLS_IDX_JUMP: class_length = LEN_IDX_JUMP;
      CLS_IDX8: class_length = LEN_IDX8;
      CLS_IDX16: class_length = LEN_IDX16;
      CLS_WAIT: class_length = LEN_WAIT;
      CLS_SOFT_INT: class_length = LEN_SOFT_INT;
      CLS_RETURN_INT: class_length = LEN_RETURN_INT;
      CLS_BRANCH: class_length = LEN_BRANCH;
      CLS_BRANCH_SUB: class_length = LEN_BRANCH_SUB;
      default: class_length = LEN_IMM8;
    endcase
  endfunction

  // stacked byte k of an interrupt frame, pushed in this order
  function automatic logic [7:0] stack_byte(
    input logic [3:0] k,
    input logic [15:0] ret,
    input logic [15:0] x,
    input logic [7:0] a,
    input logic [7:0] b,
    input logic [7:0] cc
  );
    case (k)
      4'h0: stack_byte = ret[7:0];
      4'h1: stack_byte = ret[15:8];
      4'h2: stack_byte = x[7:0];
      4'h3: stack_byte = x[15:8];
      4'h4: stack_byte = a;
      4'h5: stack_byte = b;
      default: stack_byte = cc;
    endcase
  endfunction

  assign busy = (state_reg == ST_RUN);
  assign last_cycle = busy && (cycle_reg == class_length(class_reg));
  assign done = last_cycle;
  assign accept = start && (!busy || last_cycle);
  assign cycle_next = accept ? CYCLE_FIRST : cycle_reg + 4'h1;
  assign nx_class = accept ? op_class : class_reg;
  // the byte fetched in cycle two is needed by the very next cycle
  assign offset_now = (busy && cycle_reg == 4'h2) ? data_in : offset_reg;
  assign direct_addr = {8'h00, offset_now};
  assign ret_addr = (class_reg == CLS_BRANCH_SUB) ? pc_plus2 : pc_plus1;
  assign store_word = word_ix_reg ? ix_reg : sp_reg;
  assign stk_k = cycle_next - STACK_FIRST_CYCLE;
  assign stk_k16 = {12'h000, stk_k};

  bus_addr_calc addr_calc (
    .pc(pc_reg),
    .ix(ix_reg),
    .offset(offset_now),
    .pc_plus1(pc_plus1),
    .pc_plus2(pc_plus2),
    .branch_target(branch_target),
    .idx_no_carry(idx_no_carry),
    .idx_full(idx_full)
  );

  // bus contents for the cycle that begins at the next edge
  always_comb
  begin
    nx_addr = addr_bus;
    nx_data = DATA_RESET;
    nx_vma = 1'b0;
    nx_rnw = 1'b1;
    if (accept)
    begin
      nx_addr = pc;
      nx_vma = 1'b1;
    end
    else if (!busy || last_cycle)
    begin
      nx_vma = 1'b0;
    end
    else if (cycle_next == 4'h2)
    begin
      nx_addr = pc_plus1;
      nx_vma = 1'b1;
    end
    else
    begin
      case (nx_class)
        CLS_IMM16:
        begin
          nx_addr = pc_plus2;
          nx_vma = 1'b1;
        end
        CLS_DIR8, CLS_DIR16:
        begin
          nx_addr = (cycle_next == 4'h3) ? direct_addr : direct_addr + 16'h0001;
          nx_vma = 1'b1;
        end
        CLS_DIR_ACC_STORE:
        begin
          nx_addr = direct_addr;
          nx_vma = (cycle_next == 4'h4) && !test_reg;
          nx_rnw = (cycle_next != 4'h4);
          nx_data = acc_b_reg ? acc_b_val_reg : acc_a_reg;
        end
        CLS_DIR_WORD_STORE:
        begin
          nx_addr = (cycle_next == 4'h5) ? direct_addr + 16'h0001 : direct_addr;
          nx_vma = (cycle_next != 4'h3) && !test_reg;
          nx_rnw = (cycle_next == 4'h3);
          nx_data = (cycle_next == 4'h4) ? store_word[15:8] : store_word[7:0];
        end
        CLS_IDX_JUMP, CLS_IDX8, CLS_IDX16:
        begin
          case (cycle_next)
            4'h3: nx_addr = ix_reg;
            4'h4: nx_addr = idx_no_carry;
            4'h5: nx_addr = idx_full;
            default: nx_addr = idx_full + 16'h0001;
          endcase
          nx_vma = (cycle_next >= 4'h5);
        end
        CLS_WAIT, CLS_SOFT_INT:
        begin
          if (cycle_next <= STACK_LAST_CYCLE)
          begin
            nx_addr = sp_reg - stk_k16;
            nx_vma = !test_reg;
            nx_rnw = 1'b0;
            nx_data = stack_byte(stk_k, ret_addr, ix_reg, acc_a_reg, acc_b_val_reg, ccr_reg);
          end
          else if (cycle_next == 4'ha)
          begin
            nx_addr = sp_reg - stk_k16;
          end
          else
          begin
            nx_addr = (cycle_next == 4'hb) ? VEC_SOFT_INT_HI : VEC_SOFT_INT_LO;
            nx_vma = 1'b1;
          end
        end
        CLS_RETURN_INT:
        begin
          nx_addr = sp_reg + stk_k16;
          nx_vma = (cycle_next != 4'h3);
        end
        CLS_BRANCH:
        begin
          nx_addr = (cycle_next == 4'h3) ? pc_plus2 : branch_target;
        end
        CLS_BRANCH_SUB:
        begin
          case (cycle_next)
            4'h4: nx_addr = sp_reg;
            4'h5: nx_addr = sp_reg - 16'h0001;
            4'h6: nx_addr = sp_reg - 16'h0002;
            4'h8: nx_addr = {pc_reg[15:8], branch_target[7:0]};
            default: nx_addr = pc_plus2;
          endcase
          nx_vma = (cycle_next == 4'h4 || cycle_next == 4'h5) && !test_reg;
          nx_rnw = !(cycle_next == 4'h4 || cycle_next == 4'h5);
          nx_data = (cycle_next == 4'h4) ? pc_plus2[7:0] : pc_plus2[15:8];
        end
        default:
        begin
          nx_vma = 1'b0;
        end
      endcase
    end
    // cycles with read_not_write high keep the data lines at zero
    if (nx_rnw)
    begin
      nx_data = DATA_RESET;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      cycle_reg <= CYCLE_RESET;
      class_reg <= CLS_IMM8;
    end
    else if (accept)
    begin
      state_reg <= ST_RUN;
      cycle_reg <= CYCLE_FIRST;
      class_reg <= op_class;
    end
    else if (last_cycle)
    begin
      state_reg <= ST_IDLE;
      cycle_reg <= CYCLE_RESET;
    end
    else if (busy)
    begin
      cycle_reg <= cycle_next;
    end
  end

  // operands are latched at acceptance so the sequence is stable; offset_reg is taken from data_in in cycle two
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pc_reg <= ADDR_RESET;
      sp_reg <= ADDR_RESET;
      ix_reg <= ADDR_RESET;
      acc_a_reg <= DATA_RESET;
      acc_b_val_reg <= DATA_RESET;
      ccr_reg <= DATA_RESET;
      test_reg <= 1'b0;
      acc_b_reg <= 1'b0;
      word_ix_reg <= 1'b0;
      offset_reg <= DATA_RESET;
    end
    else if (accept)
    begin
      pc_reg <= pc;
      sp_reg <= sp;
      ix_reg <= ix;
      acc_a_reg <= acc_a;
      acc_b_val_reg <= acc_b;
      ccr_reg <= ccr;
      test_reg <= test_only;
      acc_b_reg <= acc_b_sel;
      word_ix_reg <= word_ix_sel;
    end
    else if (busy && cycle_reg == 4'h2)
    begin
      offset_reg <= data_in;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      addr_bus <= ADDR_RESET;
      data_out <= DATA_RESET;
      valid_memory_access <= 1'b0;
      read_not_write <= 1'b1;
    end
    else
    begin
      addr_bus <= nx_addr;
      data_out <= nx_data;
      valid_memory_access <= nx_vma;
      read_not_write <= nx_rnw;
    end
  end

  // read data hand-up; the second return-interrupt byte is dropped
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rd_valid <= 1'b0;
      rd_data <= DATA_RESET;
      rd_cycle <= CYCLE_RESET;
    end
    else
    begin
      rd_valid <= busy && valid_memory_access && read_not_write &&
        !(class_reg == CLS_RETURN_INT && cycle_reg == 4'h2);
      if (busy && valid_memory_access && read_not_write)
      begin
        rd_data <= data_in;
        rd_cycle <= cycle_reg;
      end
    end
  end
endmodule

// *** verilog/seq_pkg.sv ***
// constants and types shared by the bus cycle sequencer
package seq_pkg;
  // instruction classes, each with its own bus cycle pattern
  typedef enum logic [3:0] {
    CLS_IMM8 = 4'h0,
    CLS_IMM16 = 4'h1,
    CLS_DIR8 = 4'h2,
    CLS_DIR16 = 4'h3,
    CLS_DIR_ACC_STORE = 4'h4,
    CLS_DIR_WORD_STORE = 4'h5,
    CLS_IDX_JUMP = 4'h6,
    CLS_IDX8 = 4'h7,
    CLS_IDX16 = 4'h8,
    CLS_WAIT = 4'h9,
    CLS_SOFT_INT = 4'ha,
    CLS_RETURN_INT = 4'hb,
    CLS_BRANCH = 4'hc,
    CLS_BRANCH_SUB = 4'hd
  } op_class_type;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } seq_state_type;

  // cycles per class
  localparam logic [3:0] LEN_IMM8 = 4'h2;
  localparam logic [3:0] LEN_IMM16 = 4'h3;
  localparam logic [3:0] LEN_DIR8 = 4'h3;
  localparam logic [3:0] LEN_DIR16 = 4'h4;
  localparam logic [3:0] LEN_DIR_ACC_STORE = 4'h4;
  localparam logic [3:0] LEN_DIR_WORD_STORE = 4'h5;
  localparam logic [3:0] LEN_IDX_JUMP = 4'h4;
  localparam logic [3:0] LEN_IDX8 = 4'h5;
  localparam logic [3:0] LEN_IDX16 = 4'h6;
  localparam logic [3:0] LEN_WAIT = 4'h9;
  localparam logic [3:0] LEN_SOFT_INT = 4'hc;
  localparam logic [3:0] LEN_RETURN_INT = 4'ha;
  localparam logic [3:0] LEN_BRANCH = 4'h4;
  localparam logic [3:0] LEN_BRANCH_SUB = 4'h8;

  // interrupt vector bytes
  localparam logic [15:0] VEC_SOFT_INT_HI = 16'hfffa;
  localparam logic [15:0] VEC_SOFT_INT_LO = 16'hfffb;

  // first and last stacking cycles
  localparam logic [3:0] STACK_FIRST_CYCLE = 4'h3;
  localparam logic [3:0] STACK_LAST_CYCLE = 4'h9;

  // bus reset values and cycle counter reset and first values
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [3:0] CYCLE_RESET = 4'h0;
  localparam logic [3:0] CYCLE_FIRST = 4'h1;
endpackage
